//--- verilog/lss_link_stats.sv
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
// Function
// - Snapshot status bits stay latched from any occurrence until the next read of the snapshot register.
// - Alarm indication only when optics error with lock error or power alarm.
// - Lock error bit follows the transceiver clock recovery failure.
// - Signal loss bit follows framer reporting no or unrecognisable signal.
// - Clock loss bit follows framer missing a valid transceiver clock.
// - Out-of-frame bit set in WAN mode while framer is unlocked.
// - Frame loss set after out-of-frame persists over three milliseconds.
// - Pointer loss bit set in WAN mode while pointers are missing.
// - High error rate bit set whenever excessive bit errors are detected.
// - Local fault bit reports the peer signal is not received correctly.
// - Remote fault bit reports the peer cannot receive our signal.
// - Checksum error counter accumulates since last read, restarts after it.
// - Errored packet counter accumulates since last read, restarts after it.
// - Good packet counter accumulates since last read, restarts after it.
// - Receive buffer error counter accumulates since last read, restarts after it.
// - Out-of-frame and pointer loss bits exist only in WAN mode.
module lss_link_stats
  import lss_pkg::*;
#(
  parameter int LOF_CYCLES = LOF_CYCLES_DF
)
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              optics_rx_error,
  input  wire logic              rx_clock_recovery_fail,
  input  wire logic              rx_low_power_alarm,
  input  wire logic              signal_absent,
  input  wire logic              recovered_clock_absent,
  input  wire logic              framing_unlocked,
  input  wire logic              frame_pointer_missing,
  input  wire logic              high_error_rate,
  input  wire logic              local_fault_flag,
  input  wire logic              remote_fault_flag,
  input  wire logic              pkt_good,
  input  wire logic              pkt_bad,
  input  wire logic              pkt_checksum_error,
  input  wire logic              rx_buffer_error,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   irq
);

  // ==========================================================
  // Pin synchronisers
  localparam int PIN_N = 10;
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_meta_reg;
  logic [PIN_N-1:0] pin_sync_reg;

  assign pin_raw = {remote_fault_flag, local_fault_flag, high_error_rate, frame_pointer_missing,
                    framing_unlocked, recovered_clock_absent, signal_absent, rx_low_power_alarm,
                    rx_clock_recovery_fail, optics_rx_error};

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end
    else
    begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v, input logic ev);
    sat_inc = (ev && (v != {CNT_W{1'b1}})) ? v + 1'b1 : v;
  endfunction

  // ==========================================================
  // Alarm evaluation, latches, counters
  logic                   wan_mode_reg;
  logic                   wan_mode_next;
  logic [31:0]            oof_timer_reg;
  logic [31:0]            oof_timer_next;
  logic                   lof_reg;
  logic                   lof_next;
  logic [ALM_W-1:0]       alarm_cur;
  logic [ALM_W-1:0]       alarm_latch_reg;
  logic [ALM_W-1:0]       alarm_latch_next;
  logic [ALM_W-1:0]       irq_stat_reg;
  logic [ALM_W-1:0]       irq_stat_next;
  logic [ALM_W-1:0]       irq_mask_reg;
  logic [ALM_W-1:0]       irq_mask_next;
  logic [CNT_W-1:0]       cnt_reg [4];
  logic [CNT_W-1:0]       cnt_next [4];
  logic [CNT_W-1:0]       shadow_reg [4];
  logic [CNT_W-1:0]       shadow_next [4];
  logic [3:0]             cnt_ev;
  logic [3:0]             s_axi_wstrb_q;
  logic [3:0]             wstrb_next;
  logic                   snap_take;
  logic                   wr_do;
  logic [ADDR_W-1:0]      wr_addr;
  logic [DATA_W-1:0]      wr_data;

  assign cnt_ev = {rx_buffer_error, pkt_good, pkt_bad, pkt_checksum_error};

  always_comb
  begin
    alarm_cur        = '0;
    alarm_cur[B_RAI] = pin_sync_reg[0] && (pin_sync_reg[1] || pin_sync_reg[2]);
    alarm_cur[B_RLE] = pin_sync_reg[1];
    alarm_cur[B_RPA] = pin_sync_reg[2];
    alarm_cur[B_LOS] = pin_sync_reg[3];
    alarm_cur[B_LOC] = pin_sync_reg[4];
    alarm_cur[B_OOF] = wan_mode_reg && pin_sync_reg[5];
    alarm_cur[B_LOF] = lof_reg;
    alarm_cur[B_LOP] = wan_mode_reg && pin_sync_reg[6];
    alarm_cur[B_BER] = pin_sync_reg[7];
    alarm_cur[B_LFT] = pin_sync_reg[8];
    alarm_cur[B_RFT] = pin_sync_reg[9];
  end

  always_comb
  begin
    wan_mode_next = wan_mode_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    if (wr_do && wr_addr == OFS_CTRL)
      wan_mode_next = wr_data[CTRL_WAN_BIT];
    if (wr_do && wr_addr == OFS_IRQ_MASK)
      irq_mask_next = wr_data[ALM_W-1:0];
    if (wr_do && wr_addr == OFS_IRQ_STAT)
      irq_stat_next = irq_stat_reg & ~wr_data[ALM_W-1:0];
    // Set beats write-one-to-clear
    irq_stat_next = irq_stat_next | alarm_cur;
    // Persistence timer runs on the raw out-of-frame level in both modes
    if (!pin_sync_reg[5])
      oof_timer_next = '0;
    else if (oof_timer_reg <= 32'(LOF_CYCLES))
      oof_timer_next = oof_timer_reg + 32'h0000_0001;
    else
      oof_timer_next = oof_timer_reg;
    lof_next = pin_sync_reg[5] && (oof_timer_reg >= 32'(LOF_CYCLES));
    // Snapshot keeps this cycle's events and restarts the interval
    if (snap_take)
      alarm_latch_next = '0;
    else
      alarm_latch_next = alarm_latch_reg | alarm_cur;
    for (int i = 0; i < 4; i++)
    begin
      if (snap_take)
      begin
        shadow_next[i] = sat_inc(cnt_reg[i], cnt_ev[i]);
        cnt_next[i]    = '0;
      end
      else
      begin
        shadow_next[i] = shadow_reg[i];
        cnt_next[i]    = sat_inc(cnt_reg[i], cnt_ev[i]);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wan_mode_reg    <= CTRL_RST;
      irq_mask_reg    <= IRQ_MASK_RST;
      irq_stat_reg    <= '0;
      oof_timer_reg   <= '0;
      lof_reg         <= 1'b0;
      alarm_latch_reg <= '0;
      irq             <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        cnt_reg[i]    <= '0;
        shadow_reg[i] <= '0;
      end
    end
    else
    begin
      wan_mode_reg    <= wan_mode_next;
      irq_mask_reg    <= irq_mask_next;
      irq_stat_reg    <= irq_stat_next;
      oof_timer_reg   <= oof_timer_next;
      lof_reg         <= lof_next;
      alarm_latch_reg <= alarm_latch_next;
      irq             <= |(irq_stat_next & irq_mask_next);
      for (int i = 0; i < 4; i++)
      begin
        cnt_reg[i]    <= cnt_next[i];
        shadow_reg[i] <= shadow_next[i];
      end
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  logic              aw_got_reg;
  logic              aw_got_next;
  logic              w_got_reg;
  logic              w_got_next;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [ADDR_W-1:0] awaddr_next;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] wdata_next;
  logic              awready_next;
  logic              wready_next;
  logic              bvalid_next;
  logic [1:0]        bresp_next;

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a[1:0] == 2'b00) && (a <= OFS_ALARM_LIVE);
  endfunction

  assign wr_do   = aw_got_reg && w_got_reg && !s_axi_bvalid && (&s_axi_wstrb_q);
  assign wr_addr = awaddr_reg;
  assign wr_data = wdata_reg;

  always_comb
  begin
    aw_got_next  = aw_got_reg;
    w_got_next   = w_got_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = s_axi_wstrb_q;
    awready_next = s_axi_awready;
    wready_next  = s_axi_wready;
    bvalid_next  = s_axi_bvalid;
    bresp_next   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_next  = 1'b1;
      awaddr_next  = s_axi_awaddr;
      awready_next = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_next  = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
      wready_next = 1'b0;
    end
    if (aw_got_reg && w_got_reg && !s_axi_bvalid)
    begin
      bvalid_next = 1'b1;
      bresp_next  = addr_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      bvalid_next  = 1'b0;
      awready_next = 1'b1;
      wready_next  = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= '0;
      s_axi_wstrb_q <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      aw_got_reg    <= aw_got_next;
      w_got_reg     <= w_got_next;
      awaddr_reg    <= awaddr_next;
      wdata_reg     <= wdata_next;
      s_axi_wstrb_q <= wstrb_next;
      s_axi_awready <= awready_next;
      s_axi_wready  <= wready_next;
      s_axi_bvalid  <= bvalid_next;
      s_axi_bresp   <= bresp_next;
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  lss_rd_state_type  rd_state_reg;
  lss_rd_state_type  rd_state_next;
  logic              arready_next;
  logic              rvalid_next;
  logic [DATA_W-1:0] rdata_next;
  logic [1:0]        rresp_next;
  logic [DATA_W-1:0] rd_word;

  assign snap_take = s_axi_arvalid && s_axi_arready && (s_axi_araddr == OFS_ALARM_SNAP);

  always_comb
  begin
    case (s_axi_araddr)
      OFS_CTRL:       rd_word = {31'h0000_0000, wan_mode_reg};
      OFS_ALARM_SNAP: rd_word = {21'h00_0000, alarm_latch_reg | alarm_cur};
      OFS_FCS_CNT:    rd_word = shadow_reg[0];
      OFS_BAD_CNT:    rd_word = shadow_reg[1];
      OFS_GOOD_CNT:   rd_word = shadow_reg[2];
      OFS_RXBUF_CNT:  rd_word = shadow_reg[3];
      OFS_IRQ_STAT:   rd_word = {21'h00_0000, irq_stat_reg};
      OFS_IRQ_MASK:   rd_word = {21'h00_0000, irq_mask_reg};
      OFS_ALARM_LIVE: rd_word = {21'h00_0000, alarm_cur};
      default:        rd_word = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    rd_state_next = rd_state_reg;
    arready_next  = s_axi_arready;
    rvalid_next   = s_axi_rvalid;
    rdata_next    = s_axi_rdata;
    rresp_next    = s_axi_rresp;
    case (rd_state_reg)
      LSS_RD_IDLE:
        if (s_axi_arvalid)
        begin
          rd_state_next = LSS_RD_RESP;
          arready_next  = 1'b0;
          rvalid_next   = 1'b1;
          rdata_next    = rd_word;
          rresp_next    = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
      LSS_RD_RESP:
        if (s_axi_rready)
        begin
          rd_state_next = LSS_RD_IDLE;
          arready_next  = 1'b1;
          rvalid_next   = 1'b0;
        end
      default:
        rd_state_next = LSS_RD_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_state_reg  <= LSS_RD_IDLE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      rd_state_reg  <= rd_state_next;
      s_axi_arready <= arready_next;
      s_axi_rvalid  <= rvalid_next;
      s_axi_rdata   <= rdata_next;
      s_axi_rresp   <= rresp_next;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_rai_needs_cause: assert property (alarm_cur[B_RAI] |-> (alarm_cur[B_RLE] || alarm_cur[B_RPA]))
    else $error("alarm indication without lock or power alarm");
  a_lan_omits_wan: assert property (!wan_mode_reg |-> (alarm_cur[B_OOF] == 1'b0 && alarm_cur[B_LOP] == 1'b0))
    else $error("wan-only bit active in lan mode");
  a_oof_follows: assert property (wan_mode_reg && pin_sync_reg[5] |-> alarm_cur[B_OOF])
    else $error("out-of-frame not reported in wan mode");
  a_lof_timing: assert property ($rose(lof_reg) |-> $past(oof_timer_reg) >= 32'(LOF_CYCLES) && $past(pin_sync_reg[5]))
    else $error("frame loss raised too early");
  a_lof_drop: assert property (!pin_sync_reg[5] |=> !lof_reg)
    else $error("frame loss held after out-of-frame ended");
  a_sticky_hold: assert property (alarm_latch_reg[B_LOS] && !snap_take |=> alarm_latch_reg[B_LOS])
    else $error("latched alarm lost without read");
  a_snap_clears: assert property (snap_take && !pkt_good |=> cnt_reg[2] == '0 && shadow_reg[2] == $past(cnt_reg[2]))
    else $error("snapshot did not capture and clear");
  a_good_count: assert property (!snap_take && pkt_good && cnt_reg[2] < 32'h0000_ffff
                                 |=> cnt_reg[2] == $past(cnt_reg[2]) + 32'h0000_0001)
    else $error("good packet not counted");
  a_fcs_count: assert property (!snap_take && !pkt_checksum_error |=> cnt_reg[0] == $past(cnt_reg[0]))
    else $error("checksum counter moved without event");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before ready");
  a_irq_level: assert property (|(irq_stat_reg & irq_mask_reg) |-> irq)
    else $error("interrupt low with unmasked status");

  c_snap_read: cover property (snap_take ##1 s_axi_rvalid && s_axi_rready);
  c_lof_rise: cover property ($rose(lof_reg));
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_irq_rise: cover property ($rose(irq));

endmodule

//--- verilog/lss_pkg.sv
package lss_pkg;

  // ==========================================================
  // Bus geometry
  localparam int          ADDR_W = 6;
  localparam int          DATA_W = 32;
  localparam int          CNT_W  = 32;

  // ==========================================================
  // Register byte offsets
  localparam logic [5:0]  OFS_CTRL       = 6'h00;
  localparam logic [5:0]  OFS_ALARM_SNAP = 6'h04;
  localparam logic [5:0]  OFS_FCS_CNT    = 6'h08;
  localparam logic [5:0]  OFS_BAD_CNT    = 6'h0c;
  localparam logic [5:0]  OFS_GOOD_CNT   = 6'h10;
  localparam logic [5:0]  OFS_RXBUF_CNT  = 6'h14;
  localparam logic [5:0]  OFS_IRQ_STAT   = 6'h18;
  localparam logic [5:0]  OFS_IRQ_MASK   = 6'h1c;
  localparam logic [5:0]  OFS_ALARM_LIVE = 6'h20;

  // ==========================================================
  // Alarm bit positions (shared by snapshot, live, irq status and mask)
  localparam int          ALM_W   = 11;
  localparam int          B_RAI   = 0;
  localparam int          B_RLE   = 1;
  localparam int          B_RPA   = 2;
  localparam int          B_LOS   = 3;
  localparam int          B_LOC   = 4;
  localparam int          B_OOF   = 5;
  localparam int          B_LOF   = 6;
  localparam int          B_LOP   = 7;
  localparam int          B_BER   = 8;
  localparam int          B_LFT   = 9;
  localparam int          B_RFT   = 10;
  localparam int          CTRL_WAN_BIT = 0;

  // ==========================================================
  // Reset values
  localparam logic        CTRL_RST     = 1'b0;
  localparam logic [10:0] IRQ_MASK_RST = 11'h000;

  // ==========================================================
  // Frame loss persistence
  localparam int          CLK_KHZ       = 10000;
  localparam int          LOF_TIME_MS   = 3;
  localparam int          LOF_CYCLES_DF = LOF_TIME_MS * CLK_KHZ;

  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  typedef enum logic [0:0] {
    LSS_RD_IDLE = 1'b0,
    LSS_RD_RESP = 1'b1
  } lss_rd_state_type;

endpackage

//--- dv/lss_optics_model.sv
`timescale 1ns/1ps
// ==========================================================
// Transceiver and framer stand-in: levels and pulses follow requests one cycle late
module lss_optics_model
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [9:0] alarm_cmd,
  input  wire logic [3:0] pkt_cmd,
  output logic [9:0]      alarm_out,
  output logic [3:0]      pkt_out
);
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarm_out <= 10'h000;
      pkt_out   <= 4'h0;
    end
    else
    begin
      alarm_out <= alarm_cmd;
      pkt_out   <= pkt_cmd;
    end
  end
endmodule

//--- dv/test_lss_link_stats.sv
`timescale 1ns/1ps
module test_lss_link_stats
  import lss_pkg::*;
;
  // ==========================================================
  // Signals
  logic              core_clk = 1'b0;
  logic              rst_n    = 1'b0;
  logic [9:0]        alarm_cmd = 10'h000;
  logic [3:0]        pkt_cmd  = 4'h0;
  logic [9:0]        alarm_w;
  logic [3:0]        pkt_w;
  logic [ADDR_W-1:0] awaddr = 6'h00;
  logic [ADDR_W-1:0] araddr = 6'h00;
  logic [DATA_W-1:0] wdata  = 32'h0;
  logic              awvalid = 1'b0;
  logic              wvalid  = 1'b0;
  logic              bready  = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready  = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]        bresp, rresp;
  logic [DATA_W-1:0] rdata;
  logic [33:0]       rd_q[$];
  logic [1:0]        b_q[$];
  logic [31:0]       cur[4] = '{default: 32'h0};
  logic [31:0]       sh[4]  = '{default: 32'h0};
  logic [31:0]       lfsr   = 32'h00017ec9;
  logic              rand_on = 1'b0;
  int                n_fail  = 0;
  int                n_tests = 0;
  localparam int     POS[10] = '{-1, B_RLE, B_RPA, B_LOS, B_LOC, B_OOF, B_LOP, B_BER, B_LFT, B_RFT};

  always #50 core_clk = ~core_clk;

  lss_optics_model u_model (.core_clk(core_clk), .rst_n(rst_n), .alarm_cmd(alarm_cmd), .pkt_cmd(pkt_cmd),
    .alarm_out(alarm_w), .pkt_out(pkt_w));

  lss_link_stats #(.LOF_CYCLES(20)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .optics_rx_error(alarm_w[0]), .rx_clock_recovery_fail(alarm_w[1]),
    .rx_low_power_alarm(alarm_w[2]), .signal_absent(alarm_w[3]), .recovered_clock_absent(alarm_w[4]),
    .framing_unlocked(alarm_w[5]), .frame_pointer_missing(alarm_w[6]), .high_error_rate(alarm_w[7]),
    .local_fault_flag(alarm_w[8]), .remote_fault_flag(alarm_w[9]), .pkt_checksum_error(pkt_w[0]),
    .pkt_bad(pkt_w[1]), .pkt_good(pkt_w[2]), .rx_buffer_error(pkt_w[3]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq));

  // ==========================================================
  // Random packet events
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  always @(posedge core_clk)
  begin
    lfsr    <= lfsr_next(lfsr);
    pkt_cmd <= rand_on ? lfsr[3:0] : 4'h0;
  end

  // ==========================================================
  // Compare and report
  task automatic check_rd(input string name, input logic [33:0] exp, input logic [33:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_sig(input string name, input logic [1:0] exp, input logic [1:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic done(input string s);
    $display("Test %s finished, failures so far %0d", s, n_fail);
  endtask

  task automatic end_sim();
    if (rd_q.size() != 0 || b_q.size() != 0)
      n_fail++;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Monitor: answers against oldest note, reference event counts
  always @(posedge core_clk)
  begin
    if (rst_n)
    begin
      if (rvalid && rready)
        check_rd("read data", rd_q.pop_front(), {rresp, rdata});
      if (bvalid && bready)
        check_sig("write response", b_q.pop_front(), bresp);
      for (int i = 0; i < 4; i++)
      begin
        cur[i] = cur[i] + 32'(pkt_w[i]);
        if (arvalid && arready && araddr == OFS_ALARM_SNAP)
        begin
          sh[i]  = cur[i];
          cur[i] = 32'h0;
        end
      end
    end
  end

  // ==========================================================
  // Bus master tasks
  task automatic rd(input logic [5:0] a, input logic [1:0] resp, input logic [31:0] d);
    @(posedge core_clk);
    rd_q.push_back({resp, d});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge core_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    @(posedge core_clk);
    b_q.push_back(resp);
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge core_clk);
      if (!aw_ok && awready)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (!bvalid);
    bready <= 1'b0;
  endtask

  // Raise alarm levels, optionally read live, drop, then read snapshot twice
  task automatic alarm_case(input logic [9:0] m, input int hold, input logic [31:0] exp, input logic live);
    @(posedge core_clk);
    alarm_cmd <= m;
    repeat (hold) @(posedge core_clk);
    if (live)
      rd(OFS_ALARM_LIVE, RESP_OKAY, exp);
    alarm_cmd <= 10'h000;
    repeat (6) @(posedge core_clk);
    rd(OFS_ALARM_SNAP, RESP_OKAY, exp);
    rd(OFS_ALARM_SNAP, RESP_OKAY, 32'h0);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [31:0] e;
    logic        wan;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(OFS_CTRL, RESP_OKAY, 32'h0);
    rd(OFS_IRQ_MASK, RESP_OKAY, 32'h0);
    rd(OFS_GOOD_CNT, RESP_OKAY, 32'h0);
    rd(6'h24, RESP_SLVERR, 32'h0);
    rd(6'h02, RESP_SLVERR, 32'h0);
    wr(6'h3c, 32'h1, RESP_SLVERR);
    done("reset and map");
    for (int w = 0; w < 2; w++)
    begin
      wan = w[0];
      wr(OFS_CTRL, {31'h0, wan}, RESP_OKAY);
      rd(OFS_CTRL, RESP_OKAY, {31'h0, wan});
      for (int k = 0; k < 10; k++)
      begin
        e = (POS[k] < 0 || (!wan && (k == 5 || k == 6))) ? 32'h0 : (32'h1 << POS[k]);
        alarm_case(10'h001 << k, 5, e, 1'b1);
      end
      alarm_case(10'h003, 5, (32'h1 << B_RAI) | (32'h1 << B_RLE), 1'b1);
      alarm_case(10'h005, 5, (32'h1 << B_RAI) | (32'h1 << B_RPA), 1'b1);
      done(wan ? "alarms wan" : "alarms lan");
    end
    alarm_case(10'h020, 12, 32'h1 << B_OOF, 1'b0);
    alarm_case(10'h020, 35, (32'h1 << B_OOF) | (32'h1 << B_LOF), 1'b0);
    done("frame loss");
    rand_on <= 1'b1;
    rd(OFS_ALARM_SNAP, RESP_OKAY, 32'h0);
    repeat (60) @(posedge core_clk);
    for (int r = 0; r < 3; r++)
    begin
      rd(OFS_ALARM_SNAP, RESP_OKAY, 32'h0);
      for (int i = 0; i < 4; i++)
        rd(OFS_FCS_CNT + 6'(4 * i), RESP_OKAY, sh[i]);
      rand_on <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    done("counters");
    wr(OFS_IRQ_STAT, 32'h7ff, RESP_OKAY);
    rd(OFS_IRQ_STAT, RESP_OKAY, 32'h0);
    wr(OFS_IRQ_MASK, 32'h1 << B_LFT, RESP_OKAY);
    rd(OFS_IRQ_MASK, RESP_OKAY, 32'h1 << B_LFT);
    alarm_case(10'h080, 5, 32'h1 << B_BER, 1'b0);
    check_sig("irq masked", 2'b00, {1'b0, irq});
    rd(OFS_IRQ_STAT, RESP_OKAY, 32'h1 << B_BER);
    alarm_case(10'h100, 5, 32'h1 << B_LFT, 1'b0);
    check_sig("irq raised", 2'b01, {1'b0, irq});
    wr(OFS_IRQ_STAT, 32'h1 << B_LFT, RESP_OKAY);
    repeat (3) @(posedge core_clk);
    check_sig("irq cleared", 2'b00, {1'b0, irq});
    rd(OFS_IRQ_STAT, RESP_OKAY, 32'h1 << B_BER);
    done("interrupt");
    repeat (4) @(posedge core_clk);
    end_sim();
  end

  initial
  begin
    repeat (30000) @(posedge core_clk);
    n_fail++;
    $display("Error watchdog expected finish seen timeout");
    end_sim();
  end
endmodule
